// File: phdr_params.svh
/*
  Offsets, bit positions, latch-bank indices and reset values of the
  detailed status and 10Base-T operations register pair.
  Assumes inclusion by the package and the register-bank module only.
*/
`ifndef PHDR_PARAMS_SVH
`define PHDR_PARAMS_SVH

// ****************************************************
// register addresses on the management frame engine
// ****************************************************
`define PHDR_ADDR_STATUS   5'h11
`define PHDR_ADDR_TENOPS   5'h12
`define PHDR_VENDOR_FIRST  5'h19
`define PHDR_VENDOR_LAST   5'h1F

// ****************************************************
// detailed status word bit positions
// ****************************************************
`define PHDR_ST_RATE       15
`define PHDR_ST_DUPLEX     14
`define PHDR_ST_AN_HI      13
`define PHDR_ST_AN_LO      11
`define PHDR_ST_SIG_LOST   10
`define PHDR_ST_PLL_ERR    9
`define PHDR_ST_FALSE_CAR  8
`define PHDR_ST_INV_SYM    7
`define PHDR_ST_HALT       6
`define PHDR_ST_PREM_END   5
`define PHDR_ST_AN_DONE    4
`define PHDR_ST_SIG_ABSENT 3
`define PHDR_ST_JABBER     2
`define PHDR_ST_REM_FAULT  1
`define PHDR_ST_LINK       0

// ****************************************************
// 10Base-T operations word bit positions
// ****************************************************
`define PHDR_OP_REM_JAB    15
`define PHDR_OP_POL_REV    14
`define PHDR_OP_BUS_HI     13
`define PHDR_OP_BUS_LO     12
`define PHDR_OP_XOVER      11
`define PHDR_OP_RX_FLOAT   10
`define PHDR_OP_VGATE      9
`define PHDR_OP_TMUX       8
`define PHDR_OP_JAB_INH    5
`define PHDR_OP_RSV4       4
`define PHDR_OP_POL_INH    3
`define PHDR_OP_SQE_INH    2
`define PHDR_OP_LL_INH     1
`define PHDR_OP_SQ_INH     0

// ****************************************************
// latch bank layout
// ****************************************************
`define PHDR_LATCH_COUNT   11
`define PHDR_LATCH_LOWMASK 11'h400
`define PHDR_LB_SIG_LOST   0
`define PHDR_LB_PLL_ERR    1
`define PHDR_LB_FALSE_CAR  2
`define PHDR_LB_INV_SYM    3
`define PHDR_LB_HALT       4
`define PHDR_LB_PREM_END   5
`define PHDR_LB_JABBER     6
`define PHDR_LB_REM_FAULT  7
`define PHDR_LB_POL_REV    8
`define PHDR_LB_REM_JAB    9
`define PHDR_LB_LINK       10
`define PHDR_LB_STATUS_CLR 11'h4FF
`define PHDR_LB_TENOPS_CLR 11'h300

// ****************************************************
// reset values
// ****************************************************
`define PHDR_AN_RST        3'h0
`define PHDR_TMUX_RST      1'b0
`define PHDR_INH_RST       1'b0
`define PHDR_RSV4_RST      1'b1
`define PHDR_BUS_RMII      2'h2
`define PHDR_WORD_ZERO     16'h0000

`endif

// File: phdr_pkg.sv
/*
  Types shared by the register bank: words, addresses, phase enum and
  the packed state of the top module with its reset image.
  Assumes phdr_params.svh is on the include path.
*/
`default_nettype none
`include "phdr_params.svh"

package phdr_pkg;

  typedef logic [15:0] phdr_word_t;
  typedef logic [4:0]  phdr_addr_t;

  typedef enum logic [1:0] {
    PHDR_PH_STRAP = 2'b01,
    PHDR_PH_RUN   = 2'b10
  } phdr_phase_e;

  typedef struct packed {
    phdr_phase_e phase;
    phdr_word_t  rdata;
    logic        rvalid;
    logic        vreject;
    logic [2:0]  an;
    logic        xover;
    logic        rx_float;
    logic        vgate;
    logic        tmux;
    logic        jab_inh;
    logic        rsv4;
    logic        pol_inh;
    logic        sqe_inh;
    logic        ll_inh;
    logic        sq_inh;
  } phdr_regs_s;

  localparam phdr_regs_s PHDR_REGS_RST = '{
    phase:    PHDR_PH_STRAP,
    rdata:    `PHDR_WORD_ZERO,
    rvalid:   1'b0,
    vreject:  1'b0,
    an:       `PHDR_AN_RST,
    xover:    1'b0,
    rx_float: 1'b0,
    vgate:    1'b0,
    tmux:     `PHDR_TMUX_RST,
    jab_inh:  `PHDR_INH_RST,
    rsv4:     `PHDR_RSV4_RST,
    pol_inh:  `PHDR_INH_RST,
    sqe_inh:  `PHDR_INH_RST,
    ll_inh:   `PHDR_INH_RST,
    sq_inh:   `PHDR_INH_RST
  };

endpackage : phdr_pkg
`default_nettype wire

// File: phdr_sync.sv
/*
  Two-stage synchroniser for strap pins.
  Assumes inputs are quasi-static levels from outside the clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module phdr_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,   // system clock
  input  wire logic [W-1:0] din,   // asynchronous level
  output logic      [W-1:0] dout   // synchronised level
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } phdr_sync_s;

  phdr_sync_s st;
  phdr_sync_s next_st;

  // no reset: the stages settle while reset is held
  always_comb begin
    next_st.meta   = din;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign dout = st.stable;

endmodule : phdr_sync
`default_nettype wire

// File: phdr_latch_bank.sv
/*
  Bank of latched status flags: latch-high bits stick at one, latch-low
  bits stick at zero, and a read clear returns each to its live value.
  Assumes live inputs and clears come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module phdr_latch_bank #(
  parameter int           N        = 11,
  parameter logic [N-1:0] LOW_MASK = '0
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rst,   // synchronous reset, active high
  input  wire logic [N-1:0] live,  // live condition per flag
  input  wire logic [N-1:0] clr,   // read clear per flag
  output logic      [N-1:0] q      // latched flags
);

  typedef struct packed {
    logic [N-1:0] lat;
  } phdr_lb_s;

  phdr_lb_s st;
  phdr_lb_s next_st;

  always_comb begin
    next_st = st;
    for (int i = 0; i < N; i++) begin
      // event in the clearing cycle survives: load the live value
      if (clr[i]) begin
        next_st.lat[i] = live[i];
      end else if (LOW_MASK[i]) begin
        next_st.lat[i] = st.lat[i] & live[i];
      end else begin
        next_st.lat[i] = st.lat[i] | live[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.lat;

endmodule : phdr_latch_bank
`default_nettype wire

// File: phdr_regs.sv
/*
  Detailed status and 10Base-T operations register pair, reached through
  the register port of the management frame engine.
  Assumes the frame engine gives one-cycle read and write strobes with a
  5-bit register address, and that datapath events arrive on SYS_CLK.
*/
// How it works
// R01: progress code bit zero, read-only, resets zero
// R02: progress code upper bits, read-only, reset zero
// R03: false carrier latches high until read
// R04: halt code-group latches high until read
// R05: premature frame end latches high until read
// R06: remote fault latches high until read
// R07: receive float bit tri-states receive outputs
// R08: vendor gate bit blocks registers 25-31
// R09: test mux select, resets zero
// R10: polarity correction inhibit, resets zero
// R11: signal quality test inhibit, resets zero
// R12: link loss inhibit forces link passing
// R13: latched-high bits hold until read
// R14: link status latches low until read
`timescale 1ns/10ps
`default_nettype none
`include "phdr_params.svh"

module phdr_regs
  import phdr_pkg::*;
(
  input  wire logic        SYS_CLK,           // 50 MHz system clock
  input  wire logic        RESET,             // synchronous reset
  input  wire logic [4:0]  REG_ADDR,          // register address
  input  wire logic        REG_RD,            // read strobe
  input  wire logic        REG_WR,            // write strobe
  input  wire logic [15:0] REG_WDATA,         // write data
  output logic      [15:0] REG_RDATA,         // read data
  output logic             REG_RVALID,        // read data valid
  output logic             VENDOR_REJECT,     // blocked vendor access
  input  wire logic        STRAP_XOVER_EN,    // crossover strap pin
  input  wire logic        STRAP_RX_FLOAT,    // receive float strap pin
  input  wire logic        STRAP_VENDOR_GATE, // vendor gate strap pin
  input  wire logic [2:0]  AN_PROGRESS,       // negotiation progress
  input  wire logic        AN_COMPLETE,       // negotiation done
  input  wire logic        RATE_100,          // 100 Mb/s mode
  input  wire logic        FULL_DUPLEX,       // full duplex mode
  input  wire logic        SIG_ABSENT,        // no 100 Mb/s signal
  input  wire logic        SIG_LOST,          // signal lost
  input  wire logic        PLL_LOCK_ERR,      // pll not locked
  input  wire logic        EV_FALSE_CARRIER,  // false carrier seen
  input  wire logic        INVALID_SYM,       // invalid symbol seen
  input  wire logic        EV_HALT,           // halt code-group seen
  input  wire logic        EV_PREMATURE_END,  // two idles, no delimiter
  input  wire logic        JABBER,            // jabber seen
  input  wire logic        EV_REMOTE_FAULT,   // partner remote fault
  input  wire logic        LINK_UP,           // live link state
  input  wire logic        POL_REVERSED,      // receive polarity reversed
  input  wire logic        REMOTE_JABBER,     // remote jabber seen
  output logic             AUTO_CROSSOVER_ENABLE, // crossover enable
  output logic             RX_OUT_FLOAT,      // float receive outputs
  output logic             VENDOR_BANK_BLOCK, // vendor bank blocked
  output logic             TEST_MUX_SELECT,   // test mux routing
  output logic             JABBER_INHIBIT,    // jabber check off
  output logic             AUTO_POL_INHIBIT,  // polarity fix off
  output logic             SQE_INHIBIT,       // signal quality test off
  output logic             LINK_LOSS_INHIBIT, // link forced passing
  output logic             SQUELCH_INHIBIT    // squelch off
);

  // ****************************************************
  // state and helpers
  // ****************************************************
  phdr_regs_s st;
  phdr_regs_s next_st;

  logic [2:0]                    strap_s;
  logic [`PHDR_LATCH_COUNT-1:0]  live;
  logic [`PHDR_LATCH_COUNT-1:0]  clr;
  logic [`PHDR_LATCH_COUNT-1:0]  lat;
  logic                          rd_status;
  logic                          rd_tenops;
  logic                          wr_tenops;
  logic                          vendor_hit;
  logic                          link_eff;
  phdr_word_t                    status_word;
  phdr_word_t                    tenops_word;

  phdr_sync #(
    .W (3)
  ) u_strap_sync (
    .clk  (SYS_CLK),
    .din  ({STRAP_XOVER_EN, STRAP_RX_FLOAT, STRAP_VENDOR_GATE}),
    .dout (strap_s)
  );

  assign rd_status  = REG_RD && (REG_ADDR == `PHDR_ADDR_STATUS);
  assign rd_tenops  = REG_RD && (REG_ADDR == `PHDR_ADDR_TENOPS);
  assign wr_tenops  = REG_WR && (REG_ADDR == `PHDR_ADDR_TENOPS);
  assign vendor_hit = (REG_ADDR >= `PHDR_VENDOR_FIRST) && (REG_ADDR <= `PHDR_VENDOR_LAST);

  // R12 link forced passing
  assign link_eff = LINK_UP | st.ll_inh;

  // ****************************************************
  // latched status flags
  // ****************************************************
  always_comb begin
    live = '0;
    live[`PHDR_LB_SIG_LOST]  = SIG_LOST;
    live[`PHDR_LB_PLL_ERR]   = PLL_LOCK_ERR;
    live[`PHDR_LB_FALSE_CAR] = EV_FALSE_CARRIER;
    live[`PHDR_LB_INV_SYM]   = INVALID_SYM;
    live[`PHDR_LB_HALT]      = EV_HALT;
    live[`PHDR_LB_PREM_END]  = EV_PREMATURE_END;
    live[`PHDR_LB_JABBER]    = JABBER;
    live[`PHDR_LB_REM_FAULT] = EV_REMOTE_FAULT;
    live[`PHDR_LB_POL_REV]   = POL_REVERSED;
    live[`PHDR_LB_REM_JAB]   = REMOTE_JABBER;
    live[`PHDR_LB_LINK]      = link_eff;
  end

  // R13 clear on read
  assign clr = ({`PHDR_LATCH_COUNT{rd_status}} & `PHDR_LB_STATUS_CLR)
             | ({`PHDR_LATCH_COUNT{rd_tenops}} & `PHDR_LB_TENOPS_CLR);

  // R03 R04 R05 R06 R14 sticky flag bank
  phdr_latch_bank #(
    .N        (`PHDR_LATCH_COUNT),
    .LOW_MASK (`PHDR_LATCH_LOWMASK)
  ) u_latch (
    .clk  (SYS_CLK),
    .rst  (RESET),
    .live (live),
    .clr  (clr),
    .q    (lat)
  );

  // ****************************************************
  // read words
  // ****************************************************
  always_comb begin
    status_word = `PHDR_WORD_ZERO;
    status_word[`PHDR_ST_RATE]       = RATE_100;
    status_word[`PHDR_ST_DUPLEX]     = FULL_DUPLEX;
    // R01 R02 progress code field
    status_word[`PHDR_ST_AN_HI:`PHDR_ST_AN_LO] = st.an;
    status_word[`PHDR_ST_SIG_LOST]   = lat[`PHDR_LB_SIG_LOST];
    status_word[`PHDR_ST_PLL_ERR]    = lat[`PHDR_LB_PLL_ERR];
    status_word[`PHDR_ST_FALSE_CAR]  = lat[`PHDR_LB_FALSE_CAR];
    status_word[`PHDR_ST_INV_SYM]    = lat[`PHDR_LB_INV_SYM];
    status_word[`PHDR_ST_HALT]       = lat[`PHDR_LB_HALT];
    status_word[`PHDR_ST_PREM_END]   = lat[`PHDR_LB_PREM_END];
    status_word[`PHDR_ST_AN_DONE]    = AN_COMPLETE;
    status_word[`PHDR_ST_SIG_ABSENT] = SIG_ABSENT;
    status_word[`PHDR_ST_JABBER]     = lat[`PHDR_LB_JABBER];
    status_word[`PHDR_ST_REM_FAULT]  = lat[`PHDR_LB_REM_FAULT];
    status_word[`PHDR_ST_LINK]       = lat[`PHDR_LB_LINK];
  end

  always_comb begin
    tenops_word = `PHDR_WORD_ZERO;
    tenops_word[`PHDR_OP_REM_JAB]  = lat[`PHDR_LB_REM_JAB];
    tenops_word[`PHDR_OP_POL_REV]  = lat[`PHDR_LB_POL_REV];
    tenops_word[`PHDR_OP_BUS_HI:`PHDR_OP_BUS_LO] = `PHDR_BUS_RMII;
    tenops_word[`PHDR_OP_XOVER]    = st.xover;
    tenops_word[`PHDR_OP_RX_FLOAT] = st.rx_float;
    tenops_word[`PHDR_OP_VGATE]    = st.vgate;
    tenops_word[`PHDR_OP_TMUX]     = st.tmux;
    tenops_word[`PHDR_OP_JAB_INH]  = st.jab_inh;
    tenops_word[`PHDR_OP_RSV4]     = st.rsv4;
    tenops_word[`PHDR_OP_POL_INH]  = st.pol_inh;
    tenops_word[`PHDR_OP_SQE_INH]  = st.sqe_inh;
    tenops_word[`PHDR_OP_LL_INH]   = st.ll_inh;
    tenops_word[`PHDR_OP_SQ_INH]   = st.sq_inh;
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    next_st         = st;
    next_st.rvalid  = REG_RD;
    next_st.rdata   = `PHDR_WORD_ZERO;
    // R08 vendor bank gate
    next_st.vreject = (REG_RD || REG_WR) && vendor_hit && st.vgate;
    if (!REG_RD) begin
      next_st.rdata = st.rdata;
    end else if (REG_ADDR == `PHDR_ADDR_STATUS) begin
      next_st.rdata = status_word;
    end else if (REG_ADDR == `PHDR_ADDR_TENOPS) begin
      next_st.rdata = tenops_word;
    end else begin
      next_st.rdata = `PHDR_WORD_ZERO;
    end

    // progress code holds its highest value until read
    if (rd_status || (AN_PROGRESS > st.an)) begin
      next_st.an = AN_PROGRESS;
    end

    if (wr_tenops) begin
      next_st.xover    = REG_WDATA[`PHDR_OP_XOVER];
      // R07 receive float control
      next_st.rx_float = REG_WDATA[`PHDR_OP_RX_FLOAT];
      // R08 vendor gate control
      next_st.vgate    = REG_WDATA[`PHDR_OP_VGATE];
      // R09 test mux control
      next_st.tmux     = REG_WDATA[`PHDR_OP_TMUX];
      next_st.jab_inh  = REG_WDATA[`PHDR_OP_JAB_INH];
      next_st.rsv4     = REG_WDATA[`PHDR_OP_RSV4];
      // R10 polarity inhibit control
      next_st.pol_inh  = REG_WDATA[`PHDR_OP_POL_INH];
      // R11 quality test inhibit
      next_st.sqe_inh  = REG_WDATA[`PHDR_OP_SQE_INH];
      // R12 link loss inhibit
      next_st.ll_inh   = REG_WDATA[`PHDR_OP_LL_INH];
      next_st.sq_inh   = REG_WDATA[`PHDR_OP_SQ_INH];
    end

    // straps win over a write in the first cycle after reset
    case (st.phase)
      PHDR_PH_STRAP: begin
        next_st.xover    = strap_s[2];
        next_st.rx_float = strap_s[1];
        next_st.vgate    = strap_s[0];
        next_st.phase    = PHDR_PH_RUN;
      end
      PHDR_PH_RUN: begin
        next_st.phase = PHDR_PH_RUN;
      end
      default: begin
        next_st.phase = PHDR_PH_RUN;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st <= PHDR_REGS_RST;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA                 = st.rdata;
  assign REG_RVALID                = st.rvalid;
  assign VENDOR_REJECT             = st.vreject;
  assign AUTO_CROSSOVER_ENABLE     = st.xover;
  assign RX_OUT_FLOAT              = st.rx_float;
  assign VENDOR_BANK_BLOCK         = st.vgate;
  assign TEST_MUX_SELECT           = st.tmux;
  assign JABBER_INHIBIT            = st.jab_inh;
  assign AUTO_POL_INHIBIT          = st.pol_inh;
  assign SQE_INHIBIT               = st.sqe_inh;
  assign LINK_LOSS_INHIBIT         = st.ll_inh;
  assign SQUELCH_INHIBIT           = st.sq_inh;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence s_ops_write;
    wr_tenops && (st.phase == PHDR_PH_RUN);
  endsequence

  // an event in a read cycle must survive the clear
  sequence s_fcar_kept;
    EV_FALSE_CARRIER || (lat[`PHDR_LB_FALSE_CAR] && !rd_status);
  endsequence

  sequence s_vendor_blocked;
    REG_RD && vendor_hit && VENDOR_BANK_BLOCK;
  endsequence

  // a read reloads the live value, which the inhibit holds at one
  sequence s_link_forced;
    LINK_LOSS_INHIBIT && (lat[`PHDR_LB_LINK] || rd_status);
  endsequence

  an_read_a : assert property (rd_status |=> REG_RDATA[11] == $past(st.an[0])) // R01
    else $error("progress bit zero misread");
  an_reset_a : assert property ($fell(RESET) |-> st.an == 3'h0) // R02
    else $error("progress code not zero after reset");
  fcar_hold_a : assert property (s_fcar_kept |=> lat[`PHDR_LB_FALSE_CAR]) // R03
    else $error("false carrier flag lost");
  halt_read_a : assert property (lat[`PHDR_LB_HALT] && rd_status |=> // R04
    REG_RVALID && REG_RDATA[6])
    else $error("halt flag not reported");
  prem_set_a : assert property (EV_PREMATURE_END |=> lat[`PHDR_LB_PREM_END]) // R05
    else $error("premature end not latched");
  rflt_read_a : assert property (rd_status |=> // R06
    REG_RDATA[1] == $past(lat[`PHDR_LB_REM_FAULT]))
    else $error("remote fault misread");
  rx_float_a : assert property (s_ops_write |=> RX_OUT_FLOAT == $past(REG_WDATA[10])) // R07
    else $error("receive float not written");
  vendor_gate_a : assert property (s_vendor_blocked |=> // R08
    VENDOR_REJECT && REG_RDATA == 16'h0000)
    else $error("vendor access not blocked");
  tmux_reset_a : assert property ($fell(RESET) |-> !TEST_MUX_SELECT) // R09
    else $error("test mux not zero after reset");
  pol_inh_a : assert property (s_ops_write |=> AUTO_POL_INHIBIT == $past(REG_WDATA[3])) // R10
    else $error("polarity inhibit not written");
  sqe_inh_a : assert property (s_ops_write |=> ##1 // R11
    SQE_INHIBIT == $past(REG_WDATA[2], 2) || $past(wr_tenops))
    else $error("quality test inhibit lost");
  link_force_a : assert property (s_link_forced |=> lat[`PHDR_LB_LINK]) // R12
    else $error("link not forced passing");
  lh_hold_a : assert property (lat[`PHDR_LB_SIG_LOST] && !rd_status |=> // R13
    lat[`PHDR_LB_SIG_LOST])
    else $error("latched-high flag dropped before read");
  link_low_a : assert property (!link_eff && !rd_status |=> !lat[`PHDR_LB_LINK]) // R14
    else $error("link latch-low not held");

endmodule : phdr_regs
`default_nettype wire

// File: phdr_mgmt_model.sv
/*
  Management-side model that issues one-cycle read and write strobes.
  Assumes the bank answers one cycle after the strobe edge.
*/
`timescale 1ns/10ps
`default_nettype none

module phdr_mgmt_model
  import phdr_pkg::*;
(
  input  wire logic       clk,    // system clock
  output phdr_addr_t      addr,   // register address
  output logic            rd,     // read strobe
  output logic            wr,     // write strobe
  output phdr_word_t      wdata,  // write data
  input  wire phdr_word_t rdata,  // read word
  input  wire logic       rvalid  // read data valid
);
  initial begin
    addr = 5'h00;
    rd = 1'h0;
    wr = 1'h0;
    wdata = 16'h0000;
  end

  // released lines show the inverse so stale values cannot pass
  task rd_word(input phdr_addr_t a, output phdr_word_t d, output logic ok);
    @(posedge clk);
    #1 addr = a;
    rd = 1'h1;
    @(posedge clk);
    #1 rd = 1'h0;
    addr = ~a;
    ok = rvalid;
    d = rdata;
  endtask : rd_word

  task wr_word(input phdr_addr_t a, input phdr_word_t w);
    @(posedge clk);
    #1 addr = a;
    wdata = w;
    wr = 1'h1;
    @(posedge clk);
    #1 wr = 1'h0;
    addr = ~a;
    wdata = ~w;
  endtask : wr_word
endmodule : phdr_mgmt_model
`default_nettype wire

// File: testbench.sv
/*
  Self-checking bench for the status and 10Base-T operations pair.
  Assumes the management model drives the register port.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench
  import phdr_pkg::*;
;
  logic       clk, rst, sx, sf, sg, link, anc, r100, fd, sab;
  logic [2:0] an;
  logic [9:0] lv;
  logic [8:0] ctl;
  logic       rd, wr, rvalid, rej;
  phdr_addr_t addr, ra;
  phdr_word_t wdata, rdata, w, re;
  int         failures, checks;
  phdr_word_t msk [10] = '{16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0040,
                           16'h0020, 16'h0004, 16'h0002, 16'h4000, 16'h8000};
  phdr_addr_t va [3] = '{5'h19, 5'h1F, 5'h05};

  phdr_mgmt_model mgmt (.clk(clk), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));

  phdr_regs DUT (.SYS_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_RD(rd), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .VENDOR_REJECT(rej),
    .STRAP_XOVER_EN(sx), .STRAP_RX_FLOAT(sf), .STRAP_VENDOR_GATE(sg),
    .AN_PROGRESS(an), .AN_COMPLETE(anc), .RATE_100(r100), .FULL_DUPLEX(fd),
    .SIG_ABSENT(sab), .SIG_LOST(lv[0]), .PLL_LOCK_ERR(lv[1]), .EV_FALSE_CARRIER(lv[2]),
    .INVALID_SYM(lv[3]), .EV_HALT(lv[4]), .EV_PREMATURE_END(lv[5]), .JABBER(lv[6]),
    .EV_REMOTE_FAULT(lv[7]), .LINK_UP(link), .POL_REVERSED(lv[8]),
    .REMOTE_JABBER(lv[9]), .AUTO_CROSSOVER_ENABLE(ctl[8]), .RX_OUT_FLOAT(ctl[7]),
    .VENDOR_BANK_BLOCK(ctl[6]), .TEST_MUX_SELECT(ctl[5]), .JABBER_INHIBIT(ctl[4]),
    .AUTO_POL_INHIBIT(ctl[3]), .SQE_INHIBIT(ctl[2]), .LINK_LOSS_INHIBIT(ctl[1]),
    .SQUELCH_INHIBIT(ctl[0]));

  // ****************************************************
  // checking helpers
  // ****************************************************
  task chk(input phdr_word_t got, input phdr_word_t exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task rdchk(input phdr_addr_t a, input phdr_word_t e);
    phdr_word_t d;
    logic       ok;
    mgmt.rd_word(a, d, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(d, e);
  endtask : rdchk

  task pulse(input int i);
    @(posedge clk);
    #1 lv[i] = 1'h1;
    @(posedge clk);
    #1 lv[i] = 1'h0;
  endtask : pulse

  task print_verdict;
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // no wait below is open-ended; this only guards a stuck simulator
  initial begin
    #200000 failures++;
    $display("unexpected at %0t: run limit reached", $time);
    print_verdict();
  end

  initial begin
    {rst, sx, sf, sg, link} = 5'h1D;
    {anc, r100, fd, sab} = 4'h0;
    an = 3'h0;
    lv = 10'h000;
    failures = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    #1 rst = 1'h0;
    rdchk(5'h11, 16'h0000);
    rdchk(5'h11, 16'h0001);
    rdchk(5'h12, 16'h2C10);
    chk({7'h00, ctl}, 16'h0180);
    for (int k = 0; k < 16; k++) begin
      w = 16'h0010 | (16'h0001 << k);
      mgmt.wr_word(5'h12, w);
      chk({7'h00, ctl}, {7'h00, w[11:8], w[5], w[3:0]});
      rdchk(5'h12, 16'h2000 | (w & 16'h0F3F));
    end
    for (int g = 1; g >= 0; g--) begin
      mgmt.wr_word(5'h12, (g == 1) ? 16'h0210 : 16'h0010);
      foreach (va[j]) begin
        rdchk(va[j], 16'h0000);
        chk({15'h0000, rej}, {15'h0000, g == 1 && va[j] != 5'h05});
        mgmt.wr_word(va[j], 16'hFFFF);
        chk({15'h0000, rej}, {15'h0000, g == 1 && va[j] != 5'h05});
      end
    end
    // hold over idle cycles before the read clears each flag
    for (int i = 0; i < 10; i++) begin
      ra = (i < 8) ? 5'h11 : 5'h12;
      re = (i < 8) ? 16'h0001 : 16'h2010;
      pulse(i);
      repeat (3) @(posedge clk);
      rdchk(ra, re | msk[i]);
      rdchk(ra, re);
    end
    mgmt.wr_word(5'h11, 16'hFFFF);
    rdchk(5'h11, 16'h0001);
    @(posedge clk);
    #1 link = 1'h0;
    @(posedge clk);
    #1 link = 1'h1;
    rdchk(5'h11, 16'h0000);
    rdchk(5'h11, 16'h0001);
    mgmt.wr_word(5'h12, 16'h0012);
    @(posedge clk);
    #1 link = 1'h0;
    @(posedge clk);
    #1 link = 1'h1;
    rdchk(5'h11, 16'h0001);
    @(posedge clk);
    #1 an = 3'h5;
    {anc, r100, fd, sab} = 4'hF;
    @(posedge clk);
    #1 an = 3'h2;
    rdchk(5'h11, 16'hE819);
    rdchk(5'h11, 16'hD019);
    // second reset with the opposite straps
    @(posedge clk);
    #1 rst = 1'h1;
    {sx, sf, sg} = 3'h1;
    repeat (4) @(posedge clk);
    #1 rst = 1'h0;
    chk({7'h00, ctl}, 16'h0000);
    rdchk(5'h12, 16'h2210);
    chk({7'h00, ctl}, 16'h0040);
    rdchk(5'h1F, 16'h0000);
    chk({15'h0000, rej}, 16'h0001);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
